// File: pkg/fcm_pkg.sv
// Shared constants, register map and carrier types of the config controller
package fcm_pkg;

  // Clock rate and strap-selected power-on delays
  localparam int unsigned CLK_KHZ       = 20000;     // 20 MHz core clock
  localparam int unsigned POR_LONG_MS   = 100;       // Delay strap tied low
  localparam int unsigned POR_SHORT_MS  = 12;        // Delay strap tied high
  localparam int unsigned POR_LONG_CYC  = POR_LONG_MS * CLK_KHZ;
  localparam int unsigned POR_SHORT_CYC = POR_SHORT_MS * CLK_KHZ;

  // Phase lengths in core cycles
  localparam int unsigned INIT_CYC      = 16;        // Register clear phase
  localparam int unsigned AS_HALF_CYC   = 4;         // Self-made clock half
  localparam int unsigned FPP_SLOW_EDGE = 4;         // Clock edges per word

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;          // Scheme and options
  localparam logic [7:0] ADDR_LEN  = 8'h04;          // Expanded byte count
  localparam logic [7:0] ADDR_DATA = 8'h08;          // Virtual load address
  localparam logic [7:0] ADDR_STAT = 8'h0c;          // Live status
  localparam logic [7:0] ADDR_SUM  = 8'h10;          // Programmed checksum

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002; // Passive serial
  localparam logic [31:0] LEN_RESET  = 32'h0000_0010;

  // Loading scheme codes held in the control word
  localparam logic [2:0] SCH_FAST_PAR  = 3'h0;       // fast_parallel_load
  localparam logic [2:0] SCH_ACT_SER   = 3'h1;       // active_serial_load
  localparam logic [2:0] SCH_PAS_SER   = 3'h2;       // passive_serial_load
  localparam logic [2:0] SCH_ASYNC_PAR = 3'h3;       // async_parallel_load
  localparam logic [2:0] SCH_BSCAN     = 3'h4;       // Boundary-scan port

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Controller phases
  typedef enum logic [2:0] {
    ST_POR, ST_WAIT, ST_LOAD, ST_INIT, ST_USER, ST_FAIL
  } fcm_state_t;

  // Control word, bits 6..0 of the control register
  typedef struct packed {
    logic       local_upd;   // Bit 6: request local update mode
    logic       mem_decomp;  // Bit 5: memory expands the stream itself
    logic       secure;      // Bit 4: stream is encrypted
    logic       compress;    // Bit 3: stream is compressed
    logic [2:0] scheme;      // Bits 2..0: loading scheme
  } fcm_ctrl_t;

  // Status word, bits 10..0 of the status register
  typedef struct packed {
    logic por_long;    // Bit 10: long power-on delay was chosen
    logic pulls_on;    // Bit 9: weak pull-ups enabled
    logic local_eff;   // Bit 8: local update mode in effect
    logic sec_eff;     // Bit 7: decryption in effect
    logic decomp_eff;  // Bit 6: own expander in effect
    logic low_volt;    // Bit 5: 1.8/1.5 V input buffer chosen
    logic chain_out;   // Bit 4: next device enabled
    logic key_bad;     // Bit 3: key check failed
    logic error;       // Bit 2: load failed
    logic loading;     // Bit 1: load in progress
    logic user;        // Bit 0: user mode
  } fcm_stat_t;

  // One byte with its qualifier
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fcm_byte_t;

endpackage : fcm_pkg

// File: rtl/fcm_sync.sv
// Two-stage synchroniser for a group of pins
module fcm_sync
  import fcm_pkg::*;
#(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);

  logic [W-1:0] meta_q;  // First stage, read only by the second

  // Both stages settle to the idle pin level under reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : fcm_sync

// File: rtl/fcm_expand.sv
// Byte stage: key check, stream decryption and run-length expansion
module fcm_expand
  import fcm_pkg::*;
#(
  parameter logic [127:0] KEY = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      clear,
  input  wire logic      decrypt_en,
  input  wire logic      decomp_en,
  input  fcm_byte_t      in_b,
  output logic           in_ready,
  output fcm_byte_t      out_b,
  output logic           key_bad
);

  logic [3:0] kidx_q;      // Key byte index, rotates over 16 bytes
  logic       hdr_done_q;  // Key check block has been seen
  logic       rep_act_q;   // Run expansion in progress
  logic [2:0] rep_q;       // Copies still to emit after this one
  logic [7:0] last_q;      // Last byte emitted, source of runs

  wire [7:0] kbyte   = KEY[{kidx_q, 3'b000} +: 8];
  wire [7:0] plain   = decrypt_en ? (in_b.data ^ kbyte) : in_b.data;
  wire       take    = in_b.valid && in_ready;
  wire       is_hdr  = decrypt_en && !hdr_done_q;
  wire       is_run  = decomp_en && plain[7];
  wire [7:0] literal = decomp_en ? {1'b0, plain[6:0]} : plain;

  // A run blocks new input; the source sees this as back-pressure
  assign in_ready = !rep_act_q;

  // Header bytes must equal the stored key, then bytes are unmasked
  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      kidx_q     <= 4'h0;
      hdr_done_q <= 1'b0;
      rep_act_q  <= 1'b0;
      rep_q      <= 3'h0;
      last_q     <= 8'h00;
      out_b      <= '0;
      key_bad    <= 1'b0;
    end else begin
      out_b.valid <= 1'b0;
      if (rep_act_q) begin  // Emit one copy of the run per cycle
        out_b <= {1'b1, last_q};
        if (rep_q == 3'h0) begin
          rep_act_q <= 1'b0;
        end else begin
          rep_q <= rep_q - 3'h1;
        end
      end else if (take) begin
        if (decrypt_en) begin
          kidx_q <= kidx_q + 4'h1;
        end
        if (is_hdr) begin  // Wrong key makes the load fail later
          if (in_b.data != kbyte) begin
            key_bad <= 1'b1;
          end
          if (kidx_q == 4'hf) begin
            hdr_done_q <= 1'b1;
          end
        end else if (is_run) begin  // Repeat count is low bits plus one
          rep_act_q <= 1'b1;
          rep_q     <= plain[2:0];
        end else begin
          out_b  <= {1'b1, literal};
          last_q <= literal;
        end
      end
    end
  end

endmodule : fcm_expand

// File: rtl/fcm_config_ctrl.sv
// Configuration and mode controller with its AXI4-Lite register slave
// Overview of operation
// - Every power-up requires a fresh load
// - After loading, clear registers, enable pins, run
// - User pins undriven until configuration completes
// - Reconfigure pin returns to command mode, reloads
// - Power-on delay 100 ms strap low, 12 ms high
// - Pull select high disables pulls before/during load
// - Buffer level select sampled at power-up only
// - Level select high picks low-voltage input buffer
// - Five schemes: parallel, serial, async, boundary-scan
// - Chain output enables next device in chain
// - Active serial offers remote update mode only
// - Self-expanding memory bypasses our own expander in fast parallel only
// - Compressed stream expanded in real time
// - Encrypted stream decrypted during serial or fast parallel loading
// - Async parallel host writes one virtual address
// - Secure serial or fast parallel load completes only with matching key
// - No expansion in async or boundary-scan schemes
module fcm_config_ctrl
  import fcm_pkg::*;
#(
  parameter int unsigned  POR_LONG  = POR_LONG_CYC,   // Cycles, strap low
  parameter int unsigned  POR_SHORT = POR_SHORT_CYC,  // Cycles, strap high
  parameter logic [127:0] KEY       = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        RESET_DELAY_SELECT,
  input  wire logic        PRECONFIG_WEAK_PULL_SELECT_N,
  input  wire logic        INPUT_BUFFER_LEVEL_SELECT,
  input  wire logic        RECONFIGURE_REQUEST_N,
  input  wire logic        CHAIN_ENABLE_IN_N,
  input  wire logic        CONFIG_DATA_CLOCK_IN,
  input  wire logic [7:0]  CONFIG_DATA_IN,
  output logic             CONFIG_DATA_CLOCK_OUT,
  output logic             CONFIG_DATA_CLOCK_OE,
  output logic             CHAIN_ENABLE_OUT_N,
  output logic             USER_IO_OE,
  output logic             USER_LOGIC_RESET_N,
  output logic             WEAK_PULL_EN,
  output logic             LOW_VOLTAGE_BUFFER_SEL,
  output logic             USER_MODE,
  output logic             CONFIG_ERROR
);

  // Merge a write into a register under its byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = new_v[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Synchronised pins, all from outside the clock domain
  logic [12:0] pins_s;
  fcm_sync #(.W(13), .RST_VAL(13'h1c00)) u_sync (
    .clk   (CLK),
    .rst_n (RESET_N),
    .d     ({RECONFIGURE_REQUEST_N, CHAIN_ENABLE_IN_N,
             PRECONFIG_WEAK_PULL_SELECT_N, CONFIG_DATA_CLOCK_IN,
             INPUT_BUFFER_LEVEL_SELECT, RESET_DELAY_SELECT,
             1'b0, CONFIG_DATA_IN[5:0]} ),
    .q     (pins_s)
  );
  logic [1:0] dhi_s;  // Upper data lines go through a separate pair of stages
  fcm_sync #(.W(2), .RST_VAL(2'h0)) u_sync_hi (
    .clk   (CLK),
    .rst_n (RESET_N),
    .d     (CONFIG_DATA_IN[7:6]),
    .q     (dhi_s)
  );
  wire       recfg_n_s = pins_s[12];
  wire       chain_n_s = pins_s[11];
  wire       pull_n_s  = pins_s[10];
  wire       lclk_s    = pins_s[9];
  wire       level_s   = pins_s[8];
  wire       delay_s   = pins_s[7];
  wire [7:0] data_s    = {dhi_s, pins_s[5:0]};

  // Registers and state
  fcm_state_t  state_q;       // Controller phase
  logic [31:0] por_cnt_q;     // Power-on delay counter
  logic [31:0] init_cnt_q;    // Initialization counter
  logic        por_long_q;    // Delay strap seen during power-on
  logic        level_q;       // Level select captured once at power-up
  fcm_ctrl_t   ctrl_q;        // Control register
  logic [31:0] len_q;         // Expected expanded bytes
  logic [31:0] done_cnt_q;    // Bytes programmed so far
  logic [31:0] sum_q;         // Running checksum of programmed bytes
  logic        lclk_d_q;      // Last link clock sample, for edges
  logic        as_clk_q;      // Self-made clock for active serial
  logic [31:0] div_q;         // Divider for the self-made clock
  logic [7:0]  sh_q;          // Serial assembly register
  logic [2:0]  bit_q;         // Serial bit position
  logic [1:0]  edge_q;        // Edge count inside a slow parallel word
  fcm_byte_t   src_q;         // Byte handed to the expander
  logic        aw_have_q;     // Write address held
  logic        w_have_q;      // Write data held
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // Expander interface
  logic      exp_ready;
  fcm_byte_t exp_out;
  logic      key_bad;

  // Scheme-derived options
  wire loading   = (state_q == ST_LOAD);
  wire sch_fpp   = (ctrl_q.scheme == SCH_FAST_PAR);
  wire sch_as    = (ctrl_q.scheme == SCH_ACT_SER);
  wire sch_ser   = sch_as || (ctrl_q.scheme == SCH_PAS_SER);
  wire sch_bus   = (ctrl_q.scheme == SCH_ASYNC_PAR) ||
                   (ctrl_q.scheme == SCH_BSCAN);
  wire sec_eff   = ctrl_q.secure && !sch_bus;
  wire dec_eff   = ctrl_q.compress && !sch_bus &&
                   !(sch_fpp && ctrl_q.mem_decomp);
  wire local_eff = ctrl_q.local_upd && !sch_as;
  wire fpp_slow  = sch_fpp && (sec_eff || dec_eff);

  // Clock edges: sampled link clock, or our own clock in active serial
  wire as_tick   = loading && sch_as && (div_q == AS_HALF_CYC - 1);
  wire link_rise = lclk_s && !lclk_d_q;
  wire data_edge = loading && (sch_as ? (as_tick && !as_clk_q) : link_rise);
  wire ser_byte  = data_edge && sch_ser && (bit_q == 3'h7);
  wire par_byte  = data_edge && sch_fpp &&
                   (!fpp_slow || edge_q == 2'(FPP_SLOW_EDGE - 1));

  // Bus decode
  wire       data_ok  = exp_ready && !src_q.valid;
  wire       wr_data  = (awaddr_q == ADDR_DATA);
  wire       wr_go    = aw_have_q && w_have_q && !S_AXI_BVALID &&
                        (!wr_data || data_ok);
  wire       wr_hit   = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_LEN) ||
                        wr_data;
  wire       bus_byte = wr_go && wr_data && loading && sch_bus;
  wire       overrun  = src_q.valid && !exp_ready;
  wire       last_b   = exp_out.valid && (done_cnt_q + 32'h1 >= len_q);
  fcm_stat_t stat;
  assign stat = '{por_long: por_long_q, pulls_on: WEAK_PULL_EN,
                  local_eff: local_eff, sec_eff: sec_eff,
                  decomp_eff: dec_eff, low_volt: level_q,
                  chain_out: !CHAIN_ENABLE_OUT_N, key_bad: key_bad,
                  error: CONFIG_ERROR, loading: loading,
                  user: USER_MODE};
  wire [31:0] rd_mux =
    (S_AXI_ARADDR == ADDR_CTRL) ? {25'h0, ctrl_q} :
    (S_AXI_ARADDR == ADDR_LEN)  ? len_q :
    (S_AXI_ARADDR == ADDR_STAT) ? {21'h0, stat} :
    (S_AXI_ARADDR == ADDR_SUM)  ? sum_q : 32'h0;
  wire rd_hit = (S_AXI_ARADDR == ADDR_CTRL) || (S_AXI_ARADDR == ADDR_LEN) ||
                (S_AXI_ARADDR == ADDR_STAT) || (S_AXI_ARADDR == ADDR_SUM) ||
                (S_AXI_ARADDR == ADDR_DATA);

  // Expander, cleared while waiting so a key failure stays readable
  fcm_expand #(.KEY(KEY)) u_expand (
    .clk        (CLK),
    .rst_n      (RESET_N),
    .clear      (state_q == ST_WAIT),
    .decrypt_en (sec_eff),
    .decomp_en  (dec_eff),
    .in_b       (src_q),
    .in_ready   (exp_ready),
    .out_b      (exp_out),
    .key_bad    (key_bad)
  );

  // Phase sequencer; reset always lands in the power-on wait
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state_q    <= ST_POR;
      por_cnt_q  <= 32'h0;
      init_cnt_q <= 32'h0;
      por_long_q <= 1'b1;
      level_q    <= 1'b0;
    end else if (state_q != ST_POR && !recfg_n_s) begin
      state_q <= ST_WAIT;
    end else begin
      case (state_q)
        ST_POR: begin  // Strap picks the delay length
          por_long_q <= !delay_s;
          por_cnt_q  <= por_cnt_q + 32'h1;
          if (por_cnt_q + 32'h1 >= (delay_s ? POR_SHORT : POR_LONG)) begin
            state_q <= ST_WAIT;
            level_q <= level_s;
          end
        end
        ST_WAIT: begin  // Held until this device is enabled in the chain
          if (!chain_n_s) state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          init_cnt_q <= 32'h0;
          if (overrun) begin
            state_q <= ST_FAIL;
          end else if (last_b) begin  // Wrong key never reaches init
            state_q <= key_bad ? ST_FAIL : ST_INIT;
          end
        end
        ST_INIT: begin
          init_cnt_q <= init_cnt_q + 32'h1;
          if (init_cnt_q + 32'h1 >= INIT_CYC) state_q <= ST_USER;
        end
        ST_USER: state_q <= ST_USER;
        ST_FAIL: state_q <= ST_FAIL;  // Left only by a reconfigure request
        default: state_q <= ST_POR;
      endcase
    end
  end

  // Pin-facing outputs, all registered
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      USER_IO_OE             <= 1'b0;
      USER_LOGIC_RESET_N     <= 1'b0;
      USER_MODE              <= 1'b0;
      CHAIN_ENABLE_OUT_N     <= 1'b1;
      WEAK_PULL_EN           <= 1'b0;
      LOW_VOLTAGE_BUFFER_SEL <= 1'b0;
      CONFIG_ERROR           <= 1'b0;
      CONFIG_DATA_CLOCK_OE   <= 1'b0;
      CONFIG_DATA_CLOCK_OUT  <= 1'b0;
    end else begin
      USER_IO_OE         <= (state_q == ST_USER);
      USER_LOGIC_RESET_N <= (state_q == ST_USER);
      USER_MODE          <= (state_q == ST_USER);
      CHAIN_ENABLE_OUT_N <= !(state_q inside {ST_INIT, ST_USER});
      WEAK_PULL_EN       <= (state_q != ST_USER) && !pull_n_s;
      LOW_VOLTAGE_BUFFER_SEL <= level_q;
      CONFIG_ERROR       <= (state_q == ST_FAIL);
      CONFIG_DATA_CLOCK_OE  <= loading && sch_as;
      CONFIG_DATA_CLOCK_OUT <= as_clk_q;
    end
  end

  // Link side: edge detect, own clock divider, byte assembly
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      lclk_d_q <= 1'b0;
      as_clk_q <= 1'b0;
      div_q    <= 32'h0;
      sh_q     <= 8'h00;
      bit_q    <= 3'h0;
      edge_q   <= 2'h0;
      src_q    <= '0;
    end else begin
      lclk_d_q    <= lclk_s;
      src_q.valid <= 1'b0;
      if (!loading) begin  // Each load starts on a byte boundary
        as_clk_q <= 1'b0;
        div_q    <= 32'h0;
        bit_q    <= 3'h0;
        edge_q   <= 2'h0;
      end else begin
        if (sch_as) begin  // We make the clock in active serial
          div_q <= as_tick ? 32'h0 : div_q + 32'h1;
          if (as_tick) as_clk_q <= !as_clk_q;
        end
        if (data_edge && sch_ser) begin  // Serial, low bit first
          sh_q  <= {data_s[0], sh_q[7:1]};
          bit_q <= bit_q + 3'h1;
        end
        if (data_edge && fpp_slow) edge_q <= edge_q + 2'h1;
        if (ser_byte) begin
          src_q <= {1'b1, data_s[0], sh_q[7:1]};
        end else if (par_byte) begin
          src_q <= {1'b1, data_s};
        end else if (bus_byte) begin
          src_q <= {1'b1, wdata_q[7:0]};
        end else if (overrun) begin
          src_q.valid <= 1'b1;  // Held so the overrun is reported
        end
      end
    end
  end

  // Programmed byte count and checksum
  always_ff @(posedge CLK) begin
    if (!RESET_N || state_q == ST_WAIT) begin
      done_cnt_q <= 32'h0;
      sum_q      <= 32'h0;
    end else if (loading && exp_out.valid) begin
      done_cnt_q <= done_cnt_q + 32'h1;
      sum_q      <= sum_q + {24'h0, exp_out.data};
    end
  end

  // AXI4-Lite write channels; data writes wait for the expander
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      ctrl_q        <= CTRL_RESET[6:0];
      len_q         <= LEN_RESET;
    end else begin
      S_AXI_AWREADY <= !aw_have_q && S_AXI_AWVALID && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_have_q && S_AXI_WVALID && !S_AXI_WREADY;
      if (S_AXI_AWREADY && S_AXI_AWVALID) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WREADY && S_AXI_WVALID) begin
        w_have_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (wr_go) begin  // Options are frozen while a load runs
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_hit ? RESP_OKAY : RESP_DECERR;
        if (awaddr_q == ADDR_CTRL && !loading) begin
          ctrl_q <= 7'(merge({25'h0, ctrl_q}, wdata_q, wstrb_q));
        end
        if (awaddr_q == ADDR_LEN && !loading) begin
          len_q <= merge(len_q, wdata_q, wstrb_q);
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
      if (S_AXI_ARREADY && S_AXI_ARVALID) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_mux;
        S_AXI_RRESP  <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule : fcm_config_ctrl

// File: verification/fcm_ctrl_properties.sv
// Concurrent checks on the mode pins of the configuration controller
module fcm_ctrl_properties (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic USER_MODE,
  input wire logic USER_IO_OE,
  input wire logic USER_LOGIC_RESET_N,
  input wire logic CHAIN_ENABLE_OUT_N,
  input wire logic RECONFIGURE_REQUEST_N,
  input wire logic WEAK_PULL_EN,
  input wire logic PRECONFIG_WEAK_PULL_SELECT_N,
  input wire logic LOW_VOLTAGE_BUFFER_SEL,
  input wire logic CONFIG_ERROR
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Pins stay undriven in command mode
  a_io_off_cmd: assert property (
    !USER_MODE |-> !USER_IO_OE) else $error("pins driven in command mode");
  a_user_run: assert property (
    USER_MODE |-> USER_IO_OE && USER_LOGIC_RESET_N) else $error("user idle");
  // Pull choice settles within the synchroniser delay
  a_pull_off: assert property (
    (!USER_MODE && PRECONFIG_WEAK_PULL_SELECT_N) [*6] |-> !WEAK_PULL_EN)
    else $error("pulls on while deselected");
  a_pull_on: assert property (
    (!USER_MODE && !PRECONFIG_WEAK_PULL_SELECT_N) [*6] |-> WEAK_PULL_EN)
    else $error("pulls off while selected");
  a_pull_user: assert property (
    USER_MODE |-> !WEAK_PULL_EN) else $error("pulls on in user mode");
  a_reconf_exit: assert property (
    !RECONFIGURE_REQUEST_N [*5] |-> !USER_MODE) else $error("no exit");
  a_level_hold: assert property (
    USER_MODE |-> $stable(LOW_VOLTAGE_BUFFER_SEL)) else $error("level moved");
  // Next device is already enabled 8 cycles before user mode rises
  a_chain_first: assert property (
    $rose(USER_MODE) |-> $past(CHAIN_ENABLE_OUT_N, 8) == 1'b0)
    else $error("user mode before init");
  a_err_idle: assert property (
    CONFIG_ERROR |-> !USER_MODE && CHAIN_ENABLE_OUT_N) else $error("err run");
  c_user: cover property ($rose(USER_MODE));
  c_exit: cover property ($fell(USER_MODE));
  c_fail: cover property ($rose(CONFIG_ERROR));
endmodule : fcm_ctrl_properties

// File: verification/fcm_host_model.sv
// Host side of the load link: data clock and data pins
module fcm_host_model (
  output logic       config_data_clock,
  output logic [7:0] dat
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock rests low between frames
  initial begin
    config_data_clock = 1'b0;
    dat  = 8'h00;
  end
  // One 400 ns data clock period, data set up a half period ahead
  task automatic pulse(input logic [7:0] v);
    dat = v;
    #200 config_data_clock = 1'b1;
    #200 config_data_clock = 1'b0;
  endtask : pulse
  // Serial byte on bit 0, LSB first; spare bits toggle
  task automatic ser(input logic [7:0] b);
    #7;
    for (int i = 0; i < 8; i++) pulse({~dat[7:1], b[i]});
    dat = ~dat; // Released: never leave a stale value
  endtask : ser
  // Parallel word held over k edges, four with decrypt or expand
  task automatic par(input logic [7:0] b, input int k);
    #7;
    repeat (k) pulse(b);
    dat = ~dat;
  endtask : par
endmodule : fcm_host_model

// File: verification/tb_fcm_config_ctrl.sv
// Self-checking bench of the configuration and mode controller
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  n_mismatch++; $display("unexpected t=%0t got %h exp %h", $time, a, e); \
  end end
module tb_fcm_config_ctrl
  import fcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK, RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_RREADY, RESET_DELAY_SELECT, CHAIN_ENABLE_IN_N;
  logic PRECONFIG_WEAK_PULL_SELECT_N, INPUT_BUFFER_LEVEL_SELECT;
  logic RECONFIGURE_REQUEST_N, CONFIG_DATA_CLOCK_IN, S_AXI_AWREADY;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic CONFIG_DATA_CLOCK_OUT, CONFIG_DATA_CLOCK_OE, CHAIN_ENABLE_OUT_N;
  logic USER_IO_OE, USER_LOGIC_RESET_N, WEAK_PULL_EN, LOW_VOLTAGE_BUFFER_SEL;
  logic USER_MODE, CONFIG_ERROR;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, CONFIG_DATA_IN;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd_q;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp_q;
  int          n_mismatch, n_compared;
  // Short power-on waits
  fcm_config_ctrl #(.POR_LONG(200), .POR_SHORT(50)) i_fcm_config_ctrl (.*);
  fcm_host_model i_fcm_host_model (.config_data_clock(CONFIG_DATA_CLOCK_IN),
                                   .dat(CONFIG_DATA_IN));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // A used-up bound counts as a mismatch and ends the run
  task automatic guard(input int n);
    if (n >= 4000) begin
      n_mismatch++;
      complete_run();
    end
  endtask : guard
  // Register write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    for (n = 0; n < 4000; n++) begin
      @(posedge CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    resp_q = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    guard(n);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    for (n = 0; n < 4000; n++) begin
      @(posedge CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    rd_q = S_AXI_RDATA;
    resp_q = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    guard(n);
  endtask : rd
  // Waits for user mode, or for the error flag when err is set
  task automatic wait_for(input bit err);
    int n;
    for (n = 0; n < 4000 && (err ? CONFIG_ERROR : USER_MODE) !== 1'b1; n++)
      @(posedge CLK);
    guard(n);
  endtask : wait_for
  // Polls status until the loader reports a load in progress
  task automatic await_load();
    int n;
    rd_q = '0;
    for (n = 0; n < 4000 && rd_q[1] !== 1'b1; n++) rd(ADDR_STAT);
    guard(n);
  endtask : await_load
  task automatic reload(input logic [31:0] c, input logic [31:0] len);
    RECONFIGURE_REQUEST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    `CHK(USER_MODE, 1'b0)
    `CHK(USER_IO_OE, 1'b0)
    wr(ADDR_CTRL, c);
    wr(ADDR_LEN, len);
    RECONFIGURE_REQUEST_N <= 1'b1;
    await_load();
  endtask : reload
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 3'h0;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    {S_AXI_WDATA, S_AXI_WSTRB} = {32'h0, 4'hf};
    {RESET_DELAY_SELECT, INPUT_BUFFER_LEVEL_SELECT} = 2'h3;
    {RECONFIGURE_REQUEST_N, CHAIN_ENABLE_IN_N} = 2'h3;
    {PRECONFIG_WEAK_PULL_SELECT_N, RESET_N} = 2'h0;
    repeat (20) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (60) @(posedge CLK);
    `CHK(WEAK_PULL_EN, 1'b1)
    `CHK(LOW_VOLTAGE_BUFFER_SEL, 1'b1)
    `CHK(USER_IO_OE, 1'b0)
    INPUT_BUFFER_LEVEL_SELECT <= 1'b0;
    rd(ADDR_CTRL);
    `CHK(rd_q, CTRL_RESET)
    rd(8'h14);
    `CHK(resp_q, RESP_DECERR)
    wr(ADDR_LEN, 32'h1);
    CHAIN_ENABLE_IN_N <= 1'b0;
    await_load();
    i_fcm_host_model.ser(8'h25);
    wait_for(1'b0);
    `CHK(CHAIN_ENABLE_OUT_N, 1'b0)
    `CHK(USER_LOGIC_RESET_N, 1'b1)
    rd(ADDR_SUM);
    `CHK(rd_q, 32'h25)
    reload(32'h08, 32'h3);
    i_fcm_host_model.par(8'h11, 4);
    i_fcm_host_model.par(8'h81, 4);
    wait_for(1'b0);
    rd(ADDR_SUM);
    `CHK(rd_q, 32'h33)
    `CHK(LOW_VOLTAGE_BUFFER_SEL, 1'b1)
    reload(32'h0b, 32'h2);
    wr(ADDR_DATA, 32'h81);
    wr(ADDR_DATA, 32'h02);
    wait_for(1'b0);
    rd(ADDR_SUM);
    `CHK(rd_q, 32'h83)
    reload(32'h12, 32'h1);
    repeat (17) i_fcm_host_model.ser(8'h00);
    wait_for(1'b1);
    rd(ADDR_STAT);
    `CHK({rd_q[3], rd_q[0]}, 2'h2)
    wr(ADDR_CTRL, 32'h41);
    rd(ADDR_STAT);
    `CHK({rd_q[10], rd_q[8]}, 2'h0)
    PRECONFIG_WEAK_PULL_SELECT_N <= 1'b1;
    repeat (8) @(posedge CLK);
    `CHK(WEAK_PULL_EN, 1'b0)
    complete_run();
  end
endmodule : tb_fcm_config_ctrl
bind fcm_config_ctrl fcm_ctrl_properties i_fcm_ctrl_properties (.*);
